// ==== rtl/spi_reg_pkg.sv ====
// Function
// - Each transaction carries exactly one forty-bit datagram, possibly as five bytes.
// - Datagram is one address byte followed by four data bytes.
// - Every register moves as a full 32-bit word.
// - Datagram bit 39 set means write, clear means read.
// - Device returns data on every transaction, read or write.
// - Register read happens once the address byte is in; result shifts out.
// - Values right aligned; signed values two's complement; bit groups integer fields.
// - Incoming data bit captured on serial clock rising edge.
// - Outgoing data bit updated after serial clock falling edge.
// - Most significant bit first, bit 39 down to bit 0.
// - Serial clock and data are ignored while chip select is high.
// - Chip select rising commits the shift register as a command; a frame of under forty clocks is dropped and flagged short instead.
// - Mode 3: clock idles high, output on falling, input on rising.
package spi_reg_pkg;
  localparam int DATAGRAM_BITS = 40;
  localparam int ADDR_BYTE_BITS = 8;
  localparam int DATA_BITS = 32;
  localparam int WRITE_BIT_POS = 39;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_ADDR_DONE = 6'h07;
  localparam logic [CNT_W-1:0] CNT_FULL = 6'h28;
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;
  // Register offsets (index within the 7-bit address field)
  localparam logic [6:0] ADDR_GLOBAL_CONFIGURATION = 7'h00;
  localparam logic [6:0] ADDR_GLOBAL_STATUS = 7'h01;
  localparam logic [31:0] GLOBAL_CONFIGURATION_RESET = 32'h00000000;
  localparam logic [7:0] PREV_ADDR_RESET = 8'h00;
  // Fields of global_status
  localparam int STATUS_SHORT_POS = 0;
  localparam int STATUS_WRITE_POS = 1;
  localparam int STATUS_COUNT_LSB = 8;
  localparam int STATUS_COUNT_MSB = 15;
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCK_MIN_CLK_RATIO = 4;
  localparam int SCK_MIN_PERIOD_NS = CLK_PERIOD_NS * SCK_MIN_CLK_RATIO;
  typedef enum logic {ST_IDLE, ST_SHIFT} link_state_t;
endpackage

// ==== rtl/spi_reg_bank.sv ====
`timescale 1ns/1ps
module spi_reg_bank
  import spi_reg_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic wr_en_in,
  input wire logic [6:0] wr_addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic rd_en_in,
  input wire logic [6:0] rd_addr_in,
  input wire logic [31:0] status_in,
  output logic [31:0] rd_data_out,
  output logic [31:0] config_out
);
  logic [31:0] config_reg, config_next;
  logic [31:0] rd_data_reg, rd_data_next;

  // Write port and registered read port
  always_comb begin
    config_next = config_reg;
    rd_data_next = rd_data_reg;
    if (wr_en_in && wr_addr_in == ADDR_GLOBAL_CONFIGURATION) begin
      config_next = wr_data_in;
    end
    if (rd_en_in) begin
      case (rd_addr_in)
        ADDR_GLOBAL_CONFIGURATION: rd_data_next = config_reg;
        ADDR_GLOBAL_STATUS: rd_data_next = status_in;
        default: rd_data_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      config_reg <= GLOBAL_CONFIGURATION_RESET;
      rd_data_reg <= 32'h00000000;
    end else if (ce_in) begin
      config_reg <= config_next;
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data_out = rd_data_reg;
  assign config_out = config_reg;
endmodule // spi_reg_bank

// ==== rtl/spi_register_slave.sv ====
`timescale 1ns/1ps
module spi_register_slave
  import spi_reg_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic sck_in,
  input wire logic sdi_in,
  input wire logic chip_select_n_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  output logic [31:0] configuration_out
);
  // Bit 0 chip select, bit 1 serial clock, bit 2 serial data
  logic [2:0] sync1_reg, sync2_reg, prev_reg;
  logic [2:0] pins;
  logic cs_n_s, sck_s, sdi_s;
  logic cs_fall, cs_rise, sck_rise, sck_fall;

  link_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [DATAGRAM_BITS-1:0] rx_reg, rx_next;
  logic [7:0] prev_addr_reg, prev_addr_next;
  logic sdo_reg, sdo_next;
  logic oe_reg, oe_next;
  logic rd_en_reg, rd_en_next;
  logic [6:0] rd_addr_reg, rd_addr_next;
  logic wr_en_reg, wr_en_next;
  logic [6:0] wr_addr_reg, wr_addr_next;
  logic [31:0] wr_data_reg, wr_data_next;
  logic short_reg, short_next;
  logic write_last_reg, write_last_next;
  logic [7:0] frames_reg, frames_next;
  logic [31:0] status_word;
  logic [31:0] rd_data;
  logic [31:0] cfg;

  assign pins = {sdi_in, sck_in, chip_select_n_in};

  // Two-stage synchronisers, then a history stage for edge detection
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_reg <= 3'h3;
      sync2_reg <= 3'h3;
      prev_reg <= 3'h3;
    end else if (ce_in) begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign cs_n_s = sync2_reg[0];
  assign sck_s = sync2_reg[1];
  assign sdi_s = sync2_reg[2];
  assign cs_fall = prev_reg[0] && !cs_n_s;
  assign cs_rise = !prev_reg[0] && cs_n_s;
  // Clock edges count only while selected
  assign sck_rise = !prev_reg[1] && sck_s && !cs_n_s;
  assign sck_fall = prev_reg[1] && !sck_s && !cs_n_s;

  // Status word seen by the host
  always_comb begin
    status_word = 32'h00000000;
    status_word[STATUS_SHORT_POS] = short_reg;
    status_word[STATUS_WRITE_POS] = write_last_reg;
    status_word[STATUS_COUNT_MSB:STATUS_COUNT_LSB] = frames_reg;
  end

  // Outgoing bit for a given number of bits already shifted
  function automatic logic out_bit(input logic [CNT_W-1:0] n, input logic [7:0] head,
                                   input logic [31:0] word);
    logic [CNT_W-1:0] idx;
    idx = 6'h00;
    if (n < 6'h08) begin
      idx = 6'h07 - n;
      out_bit = head[idx[2:0]];
    end else if (n < CNT_FULL) begin
      idx = 6'h27 - n;
      out_bit = word[idx[4:0]];
    end else begin
      out_bit = 1'b0;
    end
  endfunction

  // Transaction sequencing
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    rx_next = rx_reg;
    prev_addr_next = prev_addr_reg;
    sdo_next = sdo_reg;
    oe_next = oe_reg;
    rd_en_next = 1'b0;
    rd_addr_next = rd_addr_reg;
    wr_en_next = 1'b0;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    short_next = short_reg;
    write_last_next = write_last_reg;
    frames_next = frames_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cs_fall) begin
          state_next = ST_SHIFT;
          cnt_next = '0;
          oe_next = 1'b1;
          sdo_next = prev_addr_reg[7];
        end
      end
      ST_SHIFT: begin
        if (cs_rise) begin
          state_next = ST_IDLE;
          oe_next = 1'b0;
          if (cnt_reg >= CNT_FULL) begin
            // Commit the last forty bits as a command
            prev_addr_next = rx_reg[39:32];
            wr_en_next = rx_reg[WRITE_BIT_POS];
            wr_addr_next = rx_reg[38:32];
            wr_data_next = rx_reg[31:0];
            write_last_next = rx_reg[WRITE_BIT_POS];
            short_next = 1'b0;
            frames_next = frames_reg + 8'h01;
          end else begin
            short_next = 1'b1;
          end
        end else if (sck_rise) begin
          rx_next = {rx_reg[DATAGRAM_BITS-2:0], sdi_s};
          if (cnt_reg != CNT_MAX) begin
            cnt_next = cnt_reg + 6'h01;
          end
          if (cnt_reg == CNT_ADDR_DONE) begin
            rd_en_next = 1'b1;
            rd_addr_next = rx_reg[5:0] == 6'h00 && sdi_s == 1'b0 ? 7'h00
              : {rx_reg[5:0], sdi_s};
          end
        end else if (sck_fall) begin
          sdo_next = out_bit(cnt_reg, prev_addr_reg, rd_data);
        end
      end
      default: begin
        state_next = ST_IDLE;
        oe_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      rx_reg <= '0;
      prev_addr_reg <= PREV_ADDR_RESET;
      sdo_reg <= 1'b0;
      oe_reg <= 1'b0;
      rd_en_reg <= 1'b0;
      rd_addr_reg <= 7'h00;
      wr_en_reg <= 1'b0;
      wr_addr_reg <= 7'h00;
      wr_data_reg <= 32'h00000000;
      short_reg <= 1'b0;
      write_last_reg <= 1'b0;
      frames_reg <= 8'h00;
    end else if (ce_in) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rx_reg <= rx_next;
      prev_addr_reg <= prev_addr_next;
      sdo_reg <= sdo_next;
      oe_reg <= oe_next;
      rd_en_reg <= rd_en_next;
      rd_addr_reg <= rd_addr_next;
      wr_en_reg <= wr_en_next;
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
      short_reg <= short_next;
      write_last_reg <= write_last_next;
      frames_reg <= frames_next;
    end
  end

  // Register storage with registered read data
  spi_reg_bank u_bank (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .wr_en_in(wr_en_reg),
    .wr_addr_in(wr_addr_reg),
    .wr_data_in(wr_data_reg),
    .rd_en_in(rd_en_reg),
    .rd_addr_in(rd_addr_reg),
    .status_in(status_word),
    .rd_data_out(rd_data),
    .config_out(cfg)
  );

  assign sdo_out = sdo_reg;
  assign sdo_oe_out = oe_reg;
  assign configuration_out = cfg;
endmodule // spi_register_slave

// ==== verif/spi_slave_chk_sva.sv ====
`timescale 1ns/1ps
module spi_slave_chk (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic sck_in,
  input wire logic chip_select_n_in,
  input wire logic sdo_out,
  input wire logic sdo_oe_out,
  input wire logic [31:0] configuration_out
);
  logic [7:0] rise_reg;
  logic [7:0] rise_next;
  logic sck_reg;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // Counts serial clock rises within a frame
  always_comb begin
    rise_next = rise_reg;
    if (chip_select_n_in) begin
      rise_next = 8'h00;
    end else if (sck_in && !sck_reg && rise_reg != 8'hFF) begin
      rise_next = rise_reg + 8'h01;
    end
  end
  // Registers the frame counter
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rise_reg <= 8'h00;
      sck_reg <= 1'b1;
    end else begin
      rise_reg <= rise_next;
      sck_reg <= sck_in;
    end
  end
  oe_select_a: assert property (($fell(chip_select_n_in) ##1 !chip_select_n_in [*4])
    |-> sdo_oe_out) else $error("sdo not enabled");
  oe_hold_a: assert property (sdo_oe_out && !chip_select_n_in |=> sdo_oe_out)
    else $error("sdo enable dropped in frame");
  oe_release_a: assert property (($rose(chip_select_n_in) ##1 chip_select_n_in [*4])
    |-> !sdo_oe_out) else $error("sdo still enabled");
  cfg_frame_a: assert property (!chip_select_n_in [*5] |-> $stable(configuration_out))
    else $error("config changed in frame");
  cfg_commit_a: assert property ($changed(configuration_out)
    |-> chip_select_n_in && $past(chip_select_n_in, 3)) else $error("config changed early");
  sdo_fall_a: assert property ($changed(sdo_out) && sdo_oe_out && $past(sdo_oe_out)
    |-> !$past(sck_in, 2) || !$past(sck_in, 3)) else $error("sdo moved without fall");
  sdo_high_a: assert property ((sck_in [*4] ##0 (sdo_oe_out && $past(sdo_oe_out)))
    |-> $stable(sdo_out)) else $error("sdo moved while clock high");
  short_frame_a: assert property ($rose(chip_select_n_in) && rise_reg < 8'h28
    |=> $stable(configuration_out) [*6]) else $error("short frame committed");
endmodule // spi_slave_chk
bind spi_register_slave spi_slave_chk u_chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .sck_in(sck_in), .chip_select_n_in(chip_select_n_in), .sdo_out(sdo_out),
  .sdo_oe_out(sdo_oe_out), .configuration_out(configuration_out));

// ==== verif/spi_master_model.sv ====
`timescale 1ns/1ps
module spi_master_model (
  input wire logic clk_in,
  input wire logic sdo_in,
  output logic sck_out,
  output logic sdi_out,
  output logic chip_select_n_out
);
  // Idle: clock high, deselected
  initial begin
    sck_out = 1'b1;
    sdi_out = 1'b0;
    chip_select_n_out = 1'b1;
  end
  // Waits n system clocks, then steps just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // One frame of n serial clocks, eight system clocks each
  task automatic xfer(input logic [39:0] tx, input int n, output logic [39:0] rx);
    rx = 40'h0000000000;
    chip_select_n_out = 1'b0;
    tick(4);
    for (int i = 0; i < n; i++) begin
      sck_out = 1'b0;
      sdi_out = tx[39 - i];
      tick(4);
      sck_out = 1'b1;
      rx = {rx[38:0], sdo_in};
      tick(4);
    end
    chip_select_n_out = 1'b1;
    sdi_out = ~sdi_out; // Released line shows no stale value
    tick(8);
  endtask
endmodule // spi_master_model

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic ce_in = 1'b1;
  logic sck, sdi, cs_n, sdo_out, sdo_oe_out;
  logic [31:0] configuration_out;
  logic [39:0] rx;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  // Released line shows the inverse of the last driven bit, never a stale value
  wire sdo_line = sdo_oe_out ? sdo_out : ~sdo_out;
  spi_register_slave DUT (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
    .sck_in(sck), .sdi_in(sdi), .chip_select_n_in(cs_n), .sdo_out(sdo_out),
    .sdo_oe_out(sdo_oe_out), .configuration_out(configuration_out));
  spi_master_model u_master (.clk_in(clk_in), .sdo_in(sdo_line), .sck_out(sck),
    .sdi_out(sdi), .chip_select_n_out(cs_n));
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  // Cuts a hung run short
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Read frame with zero data bytes, checks both returned fields
  task automatic rd(input logic [7:0] a, input logic [7:0] aa, input logic [31:0] d);
    u_master.xfer({a, 32'h00000000}, 40, rx);
    `CHK(sdo_oe_out, 1'b0)
    `CHK(rx[39:32], aa)
    `CHK(rx[31:0], d)
  endtask
  // Write configuration, read it back, then status count
  task automatic write_read();
    u_master.xfer(40'h80A5C30F81, 40, rx);
    `CHK(configuration_out, 32'hA5C30F81)
    rd(8'h00, 8'h80, 32'hA5C30F81);
    rd(8'h01, 8'h00, 32'h00000200);
  endtask
  // Write to the read-only status leaves configuration alone
  task automatic write_status();
    u_master.xfer(40'h81FFFFFFFF, 40, rx);
    `CHK(configuration_out, 32'hA5C30F81)
    rd(8'h01, 8'h81, 32'h00000402);
  endtask
  // A frame one clock short is dropped and flagged
  task automatic short_frame();
    u_master.xfer(40'h8012345678, 39, rx);
    `CHK(configuration_out, 32'hA5C30F81)
    rd(8'h01, 8'h01, 32'h00000501);
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    #1;
    reset_n_in = 1'b1;
    u_master.tick(4);
    `CHK(configuration_out, 32'h00000000)
    `CHK(sdo_oe_out, 1'b0)
    write_read();
    write_status();
    short_frame();
    complete_run();
  end
endmodule // tb
